// >>> tmr_pins_model.sv
// pin-side model: count input and capture/reload trigger
`timescale 1ns/1ps
module tmr_pins_model (
  // clock
  input wire logic aclk,
  // pins driven toward the timer
  output logic external_count_input,
  output logic trigger_input
);
  // ==========================================
  // pins idle high and change just after a rising edge
  initial begin
    external_count_input = 1'b1;
    trigger_input = 1'b1;
  end
  task automatic count_edges(input int n);
    repeat (n) begin
      @(posedge aclk);
      external_count_input <= 1'b0;
      repeat (4) @(posedge aclk);
      external_count_input <= 1'b1;
      repeat (4) @(posedge aclk);
    end
  endtask
  // level held long enough for the two-stage sync and edge detect
  task automatic trig_level(input logic v);
    @(posedge aclk);
    trigger_input <= v;
    repeat (6) @(posedge aclk);
  endtask
  task automatic trig_fall();
    trig_level(1'b0);
    trig_level(1'b1);
  endtask
endmodule

// >>> tmr_pkg.sv
// constants and types for the timer 2 capture, reload and baud block
package tmr_pkg;
  // ==========================================
  // register indices (byte address = 4 * index)
  localparam logic [9:0] TMR_IDX_CTRL = 10'h0c8;
  localparam logic [9:0] TMR_IDX_MODE = 10'h0c9;
  localparam logic [9:0] TMR_IDX_RCAP_LO = 10'h0ca;
  localparam logic [9:0] TMR_IDX_RCAP_HI = 10'h0cb;
  localparam logic [9:0] TMR_IDX_CNT_LO = 10'h0cc;
  localparam logic [9:0] TMR_IDX_CNT_HI = 10'h0cd;
  localparam int TMR_ADDR_W = 12;
  localparam int TMR_IDX_LSB = 2;
  // ==========================================
  // control register fields
  localparam int TMR_CTL_TF = 7;
  localparam int TMR_CTL_EXF = 6;
  localparam int TMR_CTL_RCLK = 5;
  localparam int TMR_CTL_TCLK = 4;
  localparam int TMR_CTL_EXEN = 3;
  localparam int TMR_CTL_TR = 2;
  localparam int TMR_CTL_CT = 1;
  localparam int TMR_CTL_CPRL = 0;
  // mode register fields
  localparam int TMR_MOD_CRST = 3;
  localparam int TMR_MOD_OE = 1;
  localparam int TMR_MOD_DOWN_COUNT_ENABLE = 0;
  localparam logic [7:0] TMR_MOD_MASK = 8'h0b;
  localparam logic [7:0] TMR_REG_RST = 8'h00;
  // ==========================================
  // tick dividers in core clocks
  localparam logic [3:0] TMR_DIV_BAUD = 4'h2;
  localparam logic [3:0] TMR_DIV_SLOW = 4'hc;
  localparam logic [3:0] TMR_DIV_FAST = 4'h4;
  localparam logic [15:0] TMR_CNT_MAX = 16'hffff;
  localparam logic [15:0] TMR_CNT_ZERO = 16'h0000;
  // ==========================================
  // bus answers
  localparam logic [1:0] TMR_RESP_OKAY = 2'h0;
  localparam logic [1:0] TMR_RESP_SLVERR = 2'h2;
  // ==========================================
  // operating modes
  typedef enum logic [1:0] {
    TMR_MODE_RELOAD = 2'b00,
    TMR_MODE_UPDOWN = 2'b01,
    TMR_MODE_CAPTURE = 2'b10,
    TMR_MODE_BAUD = 2'b11
  } tmr_mode_type;
endpackage

// >>> tmr_timer2.sv
// timer 2 with capture, auto-reload, up/down, baud generation and clock out
// Behaviour
// - overflow flag rises on 16-bit overflow, and on down-count match with reload value.
// - hardware sets overflow flag only while receive and transmit clock selects are 0.
// - hardware never clears overflow flag; software writes may clear or set it.
// - external flag set by trigger falling edge or overflow per mode; software clears.
// - external or overflow flag requests timer interrupt when that interrupt is enabled.
// - receive baud source is timer 1 when select is 0, this timer when 1.
// - transmit baud source is timer 1 when select is 0, this timer when 1.
// - either clock select set forces baud-rate generator mode.
// - external enable 0 ignores trigger edges; otherwise falling edge captures or reloads, except in baud-rate generator and up/down modes.
// - run control 0 stops counting and keeps the count; 1 lets it run.
// - baud-rate generator mode ticks once every 2 core clocks.
// - timer counts internal ticks at set speed, counter counts count-input falling edges.
// - in baud mode capture select is ignored and every overflow reloads.
// - reload mode loads reload value on overflow and on enabled trigger edge.
// - capture mode copies the count on each enabled trigger falling edge.
// - capture reset clears the counter once the count has been captured.
// - output enable turns the clock-out toggle on or off.
// - in auto-reload, down-count enable with trigger level picks count direction.
// - reload registers take captured bytes and supply the 16-bit reload value.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module tmr_timer2 (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [tmr_pkg::TMR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [tmr_pkg::TMR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic external_count_input,
  input wire logic trigger_input,
  output logic clock_out,
  // core side
  input wire logic timer_speed_bit,
  input wire logic timer_irq_enable,
  input wire logic serial_var_mode,
  input wire logic timer1_overflow,
  output logic timer_irq,
  output logic rx_baud_tick,
  output logic tx_baud_tick
);
  import tmr_pkg::*;

  // ==========================================
  // register state
  logic [7:0] ctrl_q;
  logic [7:0] mode_q;
  logic [15:0] rcap_q, rcap_d;
  logic [15:0] cnt_q, cnt_d;
  logic tf_set, exf_set;

  function automatic logic [9:0] reg_index(input logic [TMR_ADDR_W-1:0] addr);
    reg_index = addr[TMR_IDX_LSB+9:TMR_IDX_LSB];
  endfunction

  function automatic logic reg_mapped(input logic [9:0] idx);
    reg_mapped = (idx >= TMR_IDX_CTRL) && (idx <= TMR_IDX_CNT_HI);
  endfunction

  // ==========================================
  // bus write side
  logic aw_full_q, w_full_q;
  logic [9:0] wr_idx_q;
  logic [7:0] wr_byte_q;
  logic wr_lane_q;
  logic wr_fire, wr_en;
  logic wr_ctrl, wr_mode, wr_rcap_lo, wr_rcap_hi, wr_cnt_lo, wr_cnt_hi;

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_en = wr_fire && wr_lane_q;
  assign wr_ctrl = wr_en && (wr_idx_q == TMR_IDX_CTRL);
  assign wr_mode = wr_en && (wr_idx_q == TMR_IDX_MODE);
  assign wr_rcap_lo = wr_en && (wr_idx_q == TMR_IDX_RCAP_LO);
  assign wr_rcap_hi = wr_en && (wr_idx_q == TMR_IDX_RCAP_HI);
  assign wr_cnt_lo = wr_en && (wr_idx_q == TMR_IDX_CNT_LO);
  assign wr_cnt_hi = wr_en && (wr_idx_q == TMR_IDX_CNT_HI);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      wr_idx_q <= '0;
    end else if (s_axi_awvalid && !aw_full_q) begin
      aw_full_q <= 1'b1;
      wr_idx_q <= reg_index(s_axi_awaddr);
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wr_byte_q <= '0;
      wr_lane_q <= 1'b0;
    end else if (s_axi_wvalid && !w_full_q) begin
      w_full_q <= 1'b1;
      wr_byte_q <= s_axi_wdata[7:0];
      wr_lane_q <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TMR_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= reg_mapped(wr_idx_q) ? TMR_RESP_OKAY : TMR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================
  // bus read side
  logic [9:0] rd_idx;
  logic [7:0] rd_byte;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx = reg_index(s_axi_araddr);

  always_comb begin
    if (rd_idx == TMR_IDX_CTRL) begin
      rd_byte = ctrl_q;
    end else if (rd_idx == TMR_IDX_MODE) begin
      rd_byte = mode_q;
    end else if (rd_idx == TMR_IDX_RCAP_LO) begin
      rd_byte = rcap_q[7:0];
    end else if (rd_idx == TMR_IDX_RCAP_HI) begin
      rd_byte = rcap_q[15:8];
    end else if (rd_idx == TMR_IDX_CNT_LO) begin
      rd_byte = cnt_q[7:0];
    end else if (rd_idx == TMR_IDX_CNT_HI) begin
      rd_byte = cnt_q[15:8];
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= TMR_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= reg_mapped(rd_idx) ? TMR_RESP_OKAY : TMR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================
  // pin synchronisers and edge detect
  logic [2:0] trig_sync_q, cin_sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_sync_q <= 3'h7;
      cin_sync_q <= 3'h7;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], trigger_input};
      cin_sync_q <= {cin_sync_q[1:0], external_count_input};
    end
  end

  // ==========================================
  // mode decode and tick generation
  tmr_mode_type mode;
  logic baud_mode, tr, trig_fall, cin_fall, fall_evt;
  logic [3:0] div, presc_q;
  logic int_tick, tick, count_up, ovf, match;

  assign baud_mode = ctrl_q[TMR_CTL_RCLK] || ctrl_q[TMR_CTL_TCLK];
  assign tr = ctrl_q[TMR_CTL_TR];

  always_comb begin
    if (baud_mode) begin
      mode = TMR_MODE_BAUD;
    end else if (ctrl_q[TMR_CTL_CPRL]) begin
      mode = TMR_MODE_CAPTURE;
    end else if (mode_q[TMR_MOD_DOWN_COUNT_ENABLE]) begin
      mode = TMR_MODE_UPDOWN;
    end else begin
      mode = TMR_MODE_RELOAD;
    end
  end

  assign trig_fall = trig_sync_q[2] && !trig_sync_q[1];
  assign cin_fall = cin_sync_q[2] && !cin_sync_q[1];
  // trigger acts only when enabled and not steering the count direction
  assign fall_evt = trig_fall && ctrl_q[TMR_CTL_EXEN] && (mode != TMR_MODE_BAUD)
                    && (mode != TMR_MODE_UPDOWN);

  assign div = baud_mode ? TMR_DIV_BAUD : (timer_speed_bit ? TMR_DIV_FAST : TMR_DIV_SLOW);
  assign int_tick = presc_q >= (div - 4'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_q <= 4'h0;
    end else if (int_tick) begin
      presc_q <= 4'h0;
    end else begin
      presc_q <= presc_q + 4'h1;
    end
  end

  assign tick = tr && ((baud_mode || !ctrl_q[TMR_CTL_CT]) ? int_tick : cin_fall);
  assign count_up = (mode != TMR_MODE_UPDOWN) || trig_sync_q[1];
  assign ovf = tick && count_up && (cnt_q == TMR_CNT_MAX);
  assign match = tick && !count_up && (cnt_q == rcap_q);

  // ==========================================
  // counter and reload/capture value
  always_comb begin
    cnt_d = cnt_q;
    rcap_d = rcap_q;
    if (tick) begin
      cnt_d = count_up ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
    end
    if (ovf && (mode != TMR_MODE_CAPTURE)) begin
      cnt_d = rcap_q;
    end
    if (match) begin
      cnt_d = TMR_CNT_MAX;
    end
    if (fall_evt && (mode == TMR_MODE_CAPTURE)) begin
      rcap_d = cnt_q;
      if (mode_q[TMR_MOD_CRST]) begin
        cnt_d = TMR_CNT_ZERO;
      end
    end else if (fall_evt) begin
      cnt_d = rcap_q;
    end
    if (wr_cnt_lo) begin
      cnt_d[7:0] = wr_byte_q;
    end
    if (wr_cnt_hi) begin
      cnt_d[15:8] = wr_byte_q;
    end
    if (wr_rcap_lo) begin
      rcap_d[7:0] = wr_byte_q;
    end
    if (wr_rcap_hi) begin
      rcap_d[15:8] = wr_byte_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= TMR_CNT_ZERO;
      rcap_q <= TMR_CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
      rcap_q <= rcap_d;
    end
  end

  // ==========================================
  // control and mode registers with sticky flags
  assign tf_set = (ovf || match) && !baud_mode;
  assign exf_set = fall_evt || ((mode == TMR_MODE_UPDOWN) && (ovf || match));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= TMR_REG_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wr_byte_q;
      end
      if (tf_set) begin
        ctrl_q[TMR_CTL_TF] <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_q[TMR_CTL_TF] <= wr_byte_q[TMR_CTL_TF];
      end
      if (exf_set) begin
        ctrl_q[TMR_CTL_EXF] <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_q[TMR_CTL_EXF] <= wr_byte_q[TMR_CTL_EXF];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= TMR_REG_RST;
    end else if (wr_mode) begin
      mode_q <= wr_byte_q & TMR_MOD_MASK;
    end
  end

  // ==========================================
  // outputs to core and pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_irq <= 1'b0;
      rx_baud_tick <= 1'b0;
      tx_baud_tick <= 1'b0;
      clock_out <= 1'b0;
    end else begin
      timer_irq <= timer_irq_enable && (ctrl_q[TMR_CTL_TF] || ctrl_q[TMR_CTL_EXF]);
      rx_baud_tick <= serial_var_mode
                      && (ctrl_q[TMR_CTL_RCLK] ? (ovf && baud_mode) : timer1_overflow);
      tx_baud_tick <= serial_var_mode
                      && (ctrl_q[TMR_CTL_TCLK] ? (ovf && baud_mode) : timer1_overflow);
      if (!mode_q[TMR_MOD_OE]) begin
        clock_out <= 1'b0;
      end else if (ovf) begin
        clock_out <= !clock_out;
      end
    end
  end

  // ==========================================
  // checks
  sequence baud_tick_s;
    tick && baud_mode ##1 baud_mode && tr;
  endsequence

  chk_ovf_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    tf_set |=> ctrl_q[TMR_CTL_TF])
    else $error("overflow flag not set after overflow");
  chk_baud_no_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (baud_mode && !wr_ctrl) |=> !$rose(ctrl_q[TMR_CTL_TF]))
    else $error("overflow flag rose in baud mode");
  chk_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_q[TMR_CTL_TF] && !wr_ctrl) |=> ctrl_q[TMR_CTL_TF])
    else $error("overflow flag cleared by hardware");
  chk_irq_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_q[TMR_CTL_EXF] && timer_irq_enable) |=> timer_irq)
    else $error("interrupt not requested for external flag");
  chk_baud_rate: assert property (@(posedge aclk) disable iff (!aresetn)
    baud_tick_s |-> !tick ##1 (tick || !tr || !baud_mode))
    else $error("baud tick not every two clocks");
  chk_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!tr && !wr_cnt_lo && !wr_cnt_hi && !fall_evt) |=> $stable(cnt_q))
    else $error("count moved while stopped");
  chk_capture_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    (fall_evt && mode == TMR_MODE_CAPTURE && !wr_rcap_lo && !wr_rcap_hi)
    |=> rcap_q == $past(cnt_q))
    else $error("capture did not copy count");
  chk_reload_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
    (ovf && mode == TMR_MODE_RELOAD && !fall_evt && !wr_cnt_lo && !wr_cnt_hi)
    |=> cnt_q == $past(rcap_q))
    else $error("reload missing after overflow");
  chk_down_match: assert property (@(posedge aclk) disable iff (!aresetn)
    (match && !wr_cnt_lo && !wr_cnt_hi) |=> (cnt_q == TMR_CNT_MAX) && ctrl_q[TMR_CTL_EXF])
    else $error("down match did not load all ones");
endmodule

// >>> tmr_timer2_tb_top.sv
// self-checking bench for the timer 2 block
`timescale 1ns/1ps
module tmr_timer2_tb_top;
  import tmr_pkg::*;
  logic aclk, aresetn;
  logic [TMR_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic external_count_input, trigger_input, clock_out, timer_speed_bit, timer_irq_enable;
  logic serial_var_mode, timer1_overflow, timer_irq, rx_baud_tick, tx_baud_tick;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  tmr_timer2 u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .external_count_input, .trigger_input, .clock_out, .timer_speed_bit,
    .timer_irq_enable, .serial_var_mode, .timer1_overflow, .timer_irq, .rx_baud_tick,
    .tx_baud_tick
  );
  tmr_pins_model u_pins (.aclk, .external_count_input, .trigger_input);
  // ==========================================
  // clock, watchdog and verdict
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ==========================================
  // register bus master
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (aw_done && w_done && s_axi_bvalid === 1'b1) break;
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [9:0] idx);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rc(input logic [9:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(rdv, exp);
  endtask
  task automatic poll();
    rdv = 32'h0;
    for (int i = 0; i < 20 && rdv[7] !== 1'b1; i++) begin
      rd(TMR_IDX_CTRL);
    end
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      rc(TMR_IDX_CTRL + 10'(i), 32'h0);
    end
    rc(10'h0ce, 32'h0);
    chk(32'(resp), 32'(TMR_RESP_SLVERR));
    wr(10'h0ce, 8'h55);
    chk(32'(resp), 32'(TMR_RESP_SLVERR));
    wr(TMR_IDX_MODE, 8'hff);
    chk(32'(resp), 32'(TMR_RESP_OKAY));
    rc(TMR_IDX_MODE, 32'(TMR_MOD_MASK));
    chk(32'(resp), 32'(TMR_RESP_OKAY));
    s_axi_wstrb <= 4'h0;
    wr(TMR_IDX_MODE, 8'h00);
    s_axi_wstrb <= 4'h1;
    rc(TMR_IDX_MODE, 32'(TMR_MOD_MASK));
    wr(TMR_IDX_MODE, 8'h00);
  endtask
  task automatic t_capture();
    wr(TMR_IDX_CNT_LO, 8'hcd);
    wr(TMR_IDX_CNT_HI, 8'hab);
    wr(TMR_IDX_CTRL, 8'h09);
    u_pins.trig_fall();
    rc(TMR_IDX_RCAP_LO, 32'hcd);
    rc(TMR_IDX_RCAP_HI, 32'hab);
    rc(TMR_IDX_CTRL, 32'h49);
    chk(32'(timer_irq), 32'h1);
    wr(TMR_IDX_CTRL, 8'h09);
    rc(TMR_IDX_CTRL, 32'h09);
    wr(TMR_IDX_MODE, 8'h08);
    u_pins.trig_fall();
    rc(TMR_IDX_CNT_LO, 32'h0);
    rc(TMR_IDX_CNT_HI, 32'h0);
    wr(TMR_IDX_MODE, 8'h00);
  endtask
  task automatic t_reload();
    wr(TMR_IDX_CTRL, 8'h00);
    wr(TMR_IDX_RCAP_LO, 8'h78);
    wr(TMR_IDX_RCAP_HI, 8'h56);
    u_pins.trig_fall();
    rc(TMR_IDX_CNT_HI, 32'h0);
    wr(TMR_IDX_CTRL, 8'h08);
    u_pins.trig_fall();
    rc(TMR_IDX_CNT_LO, 32'h78);
    rc(TMR_IDX_CNT_HI, 32'h56);
  endtask
  task automatic t_overflow();
    wr(TMR_IDX_RCAP_HI, 8'h12);
    wr(TMR_IDX_CNT_LO, 8'hfd);
    wr(TMR_IDX_CNT_HI, 8'hff);
    wr(TMR_IDX_CTRL, 8'h04);
    poll();
    chk(32'(rdv[7]), 32'h1);
    wr(TMR_IDX_CTRL, 8'h80);
    rc(TMR_IDX_CNT_HI, 32'h12);
    wr(TMR_IDX_CTRL, 8'h00);
    rc(TMR_IDX_CTRL, 32'h0);
    wr(TMR_IDX_CTRL, 8'h80);
    rc(TMR_IDX_CTRL, 32'h80);
    wr(TMR_IDX_CTRL, 8'h40);
    chk(32'(timer_irq), 32'h1);
    timer_irq_enable <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(timer_irq), 32'h0);
    timer_irq_enable <= 1'b1;
    wr(TMR_IDX_CTRL, 8'h00);
  endtask
  task automatic t_speed(input logic sp, input int n);
    logic [31:0] v;
    timer_speed_bit <= sp;
    wr(TMR_IDX_CNT_LO, 8'h00);
    wr(TMR_IDX_CNT_HI, 8'h00);
    wr(TMR_IDX_CTRL, 8'h04);
    repeat (44) @(posedge aclk);
    wr(TMR_IDX_CTRL, 8'h00);
    rd(TMR_IDX_CNT_LO);
    v = rdv;
    chk(32'(rdv[7:0] >= 8'(n - 1) && rdv[7:0] <= 8'(n + 1)), 32'h1);
    repeat (40) @(posedge aclk);
    rc(TMR_IDX_CNT_LO, v);
  endtask
  task automatic t_counter();
    wr(TMR_IDX_CNT_LO, 8'h00);
    wr(TMR_IDX_CTRL, 8'h06);
    u_pins.count_edges(5);
    wr(TMR_IDX_CTRL, 8'h00);
    rc(TMR_IDX_CNT_LO, 32'h5);
  endtask
  task automatic t_down();
    wr(TMR_IDX_MODE, 8'h01);
    wr(TMR_IDX_RCAP_LO, 8'h10);
    wr(TMR_IDX_RCAP_HI, 8'h00);
    wr(TMR_IDX_CNT_LO, 8'h12);
    u_pins.trig_level(1'b0);
    wr(TMR_IDX_CTRL, 8'h04);
    poll();
    chk(32'(rdv[7]), 32'h1);
    wr(TMR_IDX_CTRL, 8'h00);
    rc(TMR_IDX_CNT_HI, 32'hff);
    u_pins.trig_level(1'b1);
  endtask
  task automatic t_baud();
    int rx, tx, co;
    logic prev;
    rx = 0;
    tx = 0;
    co = 0;
    wr(TMR_IDX_RCAP_LO, 8'hfe);
    wr(TMR_IDX_RCAP_HI, 8'hff);
    wr(TMR_IDX_CNT_LO, 8'hfe);
    wr(TMR_IDX_CNT_HI, 8'hff);
    wr(TMR_IDX_MODE, 8'h02);
    serial_var_mode <= 1'b1;
    wr(TMR_IDX_CTRL, 8'h25);
    prev = clock_out;
    for (int i = 0; i < 60; i++) begin
      @(posedge aclk);
      timer1_overflow <= (i % 20 == 0);
      rx += int'(rx_baud_tick === 1'b1);
      tx += int'(tx_baud_tick === 1'b1);
      co += int'(clock_out !== prev);
      prev = clock_out;
    end
    chk(32'(rx >= 14 && rx <= 16), 32'h1);
    chk(32'(tx), 32'h3);
    chk(32'(co >= 14 && co <= 16), 32'h1);
    rc(TMR_IDX_CTRL, 32'h25);
    wr(TMR_IDX_MODE, 8'h00);
    chk(32'(clock_out), 32'h0);
  endtask
  // transmit select alone forces baud mode; serial mode gate stops both ticks
  task automatic t_baud_tx();
    int tx;
    tx = 0;
    wr(TMR_IDX_CTRL, 8'h14);
    repeat (40) begin
      @(posedge aclk);
      tx += int'(tx_baud_tick === 1'b1);
    end
    chk(32'(tx >= 9 && tx <= 11), 32'h1);
    rc(TMR_IDX_CTRL, 32'h14);
    serial_var_mode <= 1'b0;
    repeat (2) @(posedge aclk);
    tx = 0;
    repeat (20) begin
      @(posedge aclk);
      tx += int'(tx_baud_tick !== 1'b0 || rx_baud_tick !== 1'b0);
    end
    chk(32'(tx), 32'h0);
    wr(TMR_IDX_CTRL, 8'h00);
  endtask
  // ==========================================
  // main sequence
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    timer_speed_bit = 1'b1;
    timer_irq_enable = 1'b1;
    serial_var_mode = 1'b0;
    timer1_overflow = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_capture();
    t_reload();
    t_overflow();
    t_speed(1'b1, 12);
    t_speed(1'b0, 4);
    timer_speed_bit <= 1'b1;
    t_counter();
    t_down();
    t_baud();
    t_baud_tx();
    tally_and_finish();
  end
endmodule
